/* chan_error.sv */
// Stored error code per channel, set by the link and cleared by commands.
// Assumes set and clear requests are single-cycle pulses on pclk.
module chan_error #(
  parameter int NCH = 2,
  parameter int CW = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic set_en,
  input wire logic [CW-1:0] set_chan,
  input wire logic [7:0] set_code,
  input wire logic clr_en,
  input wire logic [CW-1:0] clr_chan,
  output logic [NCH-1:0][7:0] err_q
);
  logic [NCH-1:0][7:0] err_nxt;

  // ****************************************
  // Per-channel error code
  // ****************************************
  // A new error wins over a clear in the same cycle, so no error is lost
  always_comb begin
    err_nxt = err_q;
    for (int c = 0; c < NCH; c++) begin
      if (set_en && set_chan == CW'(c)) begin
        err_nxt[c] = set_code;
      end else if (clr_en && clr_chan == CW'(c)) begin
        err_nxt[c] = lin_diag_pkg::ERR_RESET;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= '0;
    end else begin
      err_q <= err_nxt;
    end
  end

  a_clear_error: assert property (@(posedge pclk) disable iff (!presetn)
    clr_en && !(set_en && set_chan == clr_chan) |=> err_q[$past(clr_chan)] == 8'h00)
    else $error("error code not cleared");

endmodule : chan_error

/* diag_buffer.sv */
// Byte store with one region per channel, one write and one read port.
// Assumes BUF_DEPTH is a power of two so the address is {channel, index}.
module diag_buffer #(
  parameter int NCH = 2,
  parameter int DEPTH = 64,
  parameter int CW = 1,
  parameter int AW = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [CW-1:0] wr_chan,
  input wire logic [AW-1:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [CW-1:0] rd_chan,
  input wire logic [AW-1:0] rd_idx,
  output logic [7:0] rd_data
);
  localparam int ENTRIES = 2 ** (CW + AW);

  logic [7:0] mem_r [ENTRIES];

  // ****************************************
  // Storage, one flip-flop byte per entry
  // ****************************************
  for (genvar e = 0; e < ENTRIES; e++) begin : g_ent
    // Channel sits in the upper address bits, so regions never overlap
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mem_r[e] <= 8'h00;
      end else if (wr_en && {wr_chan, wr_idx} == (CW + AW)'(e)) begin
        mem_r[e] <= wr_data;
      end
    end
  end

  // Asynchronous read; the caller registers it
  assign rd_data = mem_r[{rd_chan, rd_idx}];

endmodule : diag_buffer

/* lin_diag_pkg.sv */
// Shared constants for the LIN diagnostic session command block.
// Assumes a 32-bit APB register slave and byte-wide request/response streams.
package lin_diag_pkg;

  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0] OP_START = 8'hA1;
  localparam logic [7:0] OP_SEND = 8'hA2;
  localparam logic [7:0] OP_FETCH = 8'hA3;
  localparam logic [7:0] OP_STOP = 8'hA4;
  localparam logic [7:0] OP_STATE = 8'hA5;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] ADDR_PARAM0 = 8'h00;
  localparam logic [7:0] ADDR_PARAM1 = 8'h04;
  localparam logic [7:0] ADDR_OPCODE = 8'h08;
  localparam logic [7:0] ADDR_TXDATA = 8'h0C;
  localparam logic [7:0] ADDR_REPLY0 = 8'h10;
  localparam logic [7:0] ADDR_REPLY1 = 8'h14;
  localparam logic [7:0] ADDR_RXDATA = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;

  // ****************************************
  // Fields, codes and reset values
  // ****************************************
  localparam int MODE_NO_RESP_BIT = 7;
  localparam int FLG_SEG = 0;
  localparam int FLG_BUSY = 1;
  localparam int FLG_VALID = 2;
  localparam int FLG_PEND = 3;
  localparam int GS_BUSY = 0;
  localparam int GS_PEND = 1;
  localparam int STS_PEND = 0;
  localparam int STS_TXBUSY = 1;
  localparam int STS_REJECT = 2;
  localparam int SEND_HDR_BYTES = 8;
  localparam int STOP_HDR_BYTES = 4;
  localparam logic [2:0] SES_UNINIT = 3'h0;
  localparam logic [2:0] SES_NOCONN = 3'h1;
  localparam logic [2:0] SES_CONNECTING = 3'h2;
  localparam logic [2:0] SES_CONNECTED = 3'h3;
  localparam logic [2:0] SES_RELEASED = 3'h4;
  localparam logic [7:0] ERR_RESET = 8'h00;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {TX_IDLE, TX_LOAD, TX_SHOW} tx_state_type;

endpackage : lin_diag_pkg

/* lin_diag_session_cmds.sv */
// Command decoder and buffer manager for per-channel LIN diagnostic sessions.
// Assumes an APB master on pclk and a link engine on pclk driving tx/rsp/err.
//
// Overview of operation
// - Channel byte, addressing mode, no-response bit
// - Send byte: store only, or transmit
// - Append byte: restart or continue buffer
// - Segmentation flag byte four, byte five reserved
// - Length in bytes six-seven, data follows
// - Code A3 reads channel response buffer
// - Long responses fetched repeatedly, last remaining zero
// - Fetch flags: segment, busy, valid, not empty
// - Fetch reply byte three holds state
// - Reply length, outstanding count, then data
// - Reply byte one holds last error
// - Stop ends session, releases connection
// - Stop carries mode, final length, data
// - Get-state reports error before clearing
// - Error cleared on start, nonzero stop
// - Send valid only on connected channel
// - Get-state byte one selects error clearing
//
// Design decisions made here: the register offsets and the APB register port.
module lin_diag_session_cmds #(
  parameter int NCH = 2,
  parameter int PARAM_AREA = 64,
  parameter int BUF_DEPTH = 64,
  localparam int CW = (NCH > 1) ? $clog2(NCH) : 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  output logic tx_last,
  output logic [CW-1:0] tx_chan,
  output logic tx_functional,
  output logic tx_no_resp,
  output logic tx_seg,
  input wire logic rsp_valid,
  input wire logic [CW-1:0] rsp_chan,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_last,
  input wire logic rsp_seg,
  input wire logic err_valid,
  input wire logic [CW-1:0] err_chan,
  input wire logic [7:0] err_code,
  input wire logic [7:0] diag_type
);
  localparam int AW = $clog2(BUF_DEPTH);
  localparam logic [15:0] SEND_MAX = 16'(PARAM_AREA - lin_diag_pkg::SEND_HDR_BYTES);
  localparam logic [15:0] STOP_MAX = 16'(PARAM_AREA - lin_diag_pkg::STOP_HDR_BYTES);
  localparam logic [16:0] DEPTH_C = 17'(BUF_DEPTH);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt, param0_r, param0_nxt, param1_r, param1_nxt;
  logic [31:0] reply0_r, reply0_nxt, reply1_r, reply1_nxt;
  logic reject_r, reject_nxt;
  logic [NCH-1:0][2:0] state_r, state_nxt;
  logic [NCH-1:0][AW:0] req_cnt_r, req_cnt_nxt, rsp_wr_r, rsp_wr_nxt, rsp_rd_r, rsp_rd_nxt;
  logic [NCH-1:0] rsp_seg_r, rsp_seg_nxt, rsp_done_r, rsp_done_nxt, busy_r, busy_nxt;
  logic pend_r, pend_nxt, pend_send_r, pend_send_nxt, pend_func_r, pend_func_nxt;
  logic pend_nr_r, pend_nr_nxt, pend_seg_r, pend_seg_nxt;
  logic [CW-1:0] pend_chan_r, pend_chan_nxt, rx_chan_r, rx_chan_nxt;
  logic [15:0] pend_left_r, pend_left_nxt, rx_left_r, rx_left_nxt;
  lin_diag_pkg::tx_state_type tx_st_r, tx_st_nxt;
  logic [CW-1:0] tx_chan_r, tx_chan_nxt;
  logic [AW:0] tx_ptr_r, tx_ptr_nxt, tx_total_r, tx_total_nxt;
  logic [7:0] tx_data_r, tx_data_nxt;
  logic tx_valid_r, tx_valid_nxt, tx_last_r, tx_last_nxt;
  logic tx_func_r, tx_func_nxt, tx_nr_r, tx_nr_nxt, tx_seg_r, tx_seg_nxt;

  logic wr_fire, rd_fire, cmd_go, txd_go, tx_done, tx_start, clr_en, accept;
  logic [7:0] ch8, mode, req_rd_data, rsp_rd_data;
  logic [CW-1:0] chi;
  logic ch_ok;
  logic [15:0] len_send, len_stop, avail, chunk;
  logic [16:0] base;
  logic [NCH-1:0][7:0] err_q;
  logic rsp_ok;

  // ****************************************
  // APB handshake and command fields
  // ****************************************
  // One wait state lets read data come from a flip-flop
  assign wr_fire = psel && penable && pready_r && pwrite;
  assign rd_fire = psel && penable && pready_r && !pwrite;
  assign cmd_go = wr_fire && paddr == lin_diag_pkg::ADDR_OPCODE;
  assign txd_go = wr_fire && paddr == lin_diag_pkg::ADDR_TXDATA && pend_r;
  assign ch8 = param0_r[7:0];
  assign ch_ok = ch8 < 8'(NCH);
  assign chi = ch8[CW-1:0];
  assign mode = param0_r[15:8];
  assign len_send = {param1_r[31:24], param1_r[23:16]};
  assign len_stop = {param0_r[31:24], param0_r[23:16]};
  assign avail = 16'(rsp_wr_r[chi] - rsp_rd_r[chi]);
  assign chunk = (avail > SEND_MAX) ? SEND_MAX : avail;
  assign base = (param0_r[24] && ch_ok) ? 17'(req_cnt_r[chi]) : 17'h0_0000;
  assign tx_done = tx_valid_r && tx_ready && tx_last_r;
  assign rsp_ok = rsp_valid && rsp_chan <= CW'(NCH - 1) && rsp_wr_r[rsp_chan] < DEPTH_C[AW:0];

  // ****************************************
  // Register bus, commands and channel state
  // ****************************************
  always_comb begin
    pready_nxt = psel && penable && !pready_r;
    pslverr_nxt = 1'b0;
    prdata_nxt = prdata_r;
    {param0_nxt, param1_nxt, reply0_nxt, reply1_nxt} = {param0_r, param1_r, reply0_r, reply1_r};
    {reject_nxt, state_nxt, req_cnt_nxt} = {reject_r, state_r, req_cnt_r};
    {rsp_wr_nxt, rsp_rd_nxt, rsp_seg_nxt} = {rsp_wr_r, rsp_rd_r, rsp_seg_r};
    {rsp_done_nxt, busy_nxt} = {rsp_done_r, busy_r};
    {pend_nxt, pend_send_nxt, pend_func_nxt, pend_nr_nxt} = {pend_r, pend_send_r, pend_func_r, pend_nr_r};
    {pend_seg_nxt, pend_chan_nxt, pend_left_nxt} = {pend_seg_r, pend_chan_r, pend_left_r};
    {rx_chan_nxt, rx_left_nxt} = {rx_chan_r, rx_left_r};
    tx_start = 1'b0;
    clr_en = 1'b0;
    accept = 1'b0;
    // Read data is sampled in the first access cycle, shown with pready
    if (psel && penable && !pready_r) begin
      unique case (paddr)
        lin_diag_pkg::ADDR_PARAM0: prdata_nxt = param0_r;
        lin_diag_pkg::ADDR_PARAM1: prdata_nxt = param1_r;
        lin_diag_pkg::ADDR_OPCODE, lin_diag_pkg::ADDR_TXDATA: prdata_nxt = 32'h0000_0000;
        lin_diag_pkg::ADDR_REPLY0: prdata_nxt = reply0_r;
        lin_diag_pkg::ADDR_REPLY1: prdata_nxt = reply1_r;
        lin_diag_pkg::ADDR_RXDATA: prdata_nxt = {24'h00_0000, (rx_left_r != 16'h0000) ? rsp_rd_data : 8'h00};
        lin_diag_pkg::ADDR_STATUS: prdata_nxt = {29'h0000_0000, reject_r, tx_st_r != lin_diag_pkg::TX_IDLE, pend_r};
        default: begin
          prdata_nxt = 32'h0000_0000;
          pslverr_nxt = 1'b1;
        end
      endcase
    end
    if (wr_fire && paddr == lin_diag_pkg::ADDR_PARAM0) param0_nxt = pwdata;
    if (wr_fire && paddr == lin_diag_pkg::ADDR_PARAM1) param1_nxt = pwdata;
    // Response bytes from the link land in the addressed channel only
    if (rsp_ok) begin
      rsp_wr_nxt[rsp_chan] = rsp_wr_r[rsp_chan] + 1'b1;
      rsp_seg_nxt[rsp_chan] = rsp_seg;
      if (rsp_last) begin
        rsp_done_nxt[rsp_chan] = 1'b1;
        busy_nxt[rsp_chan] = 1'b0;
      end
    end
    if (tx_done && tx_nr_r) busy_nxt[tx_chan_r] = 1'b0;
    // Draining the response buffer; pointers rewind once it is empty
    if (rd_fire && paddr == lin_diag_pkg::ADDR_RXDATA && rx_left_r != 16'h0000) begin
      rx_left_nxt = rx_left_r - 16'h0001;
      rsp_rd_nxt[rx_chan_r] = rsp_rd_r[rx_chan_r] + 1'b1;
      if (rsp_rd_nxt[rx_chan_r] == rsp_wr_r[rx_chan_r] && !(rsp_ok && rsp_chan == rx_chan_r)) begin
        rsp_rd_nxt[rx_chan_r] = '0;
        rsp_wr_nxt[rx_chan_r] = '0;
        rsp_done_nxt[rx_chan_r] = 1'b0;
      end
    end
    // Payload bytes of a send or final stop request
    if (txd_go) begin
      req_cnt_nxt[pend_chan_r] = req_cnt_r[pend_chan_r] + 1'b1;
      pend_left_nxt = pend_left_r - 16'h0001;
      if (pend_left_r == 16'h0001) begin
        pend_nxt = 1'b0;
        tx_start = pend_send_r;
        if (pend_send_r) busy_nxt[pend_chan_r] = 1'b1;
      end
    end
    if (cmd_go) begin
      reject_nxt = 1'b0;
      unique case (pwdata[7:0])
        lin_diag_pkg::OP_START: begin
          accept = ch_ok;
          if (accept) begin
            state_nxt[chi] = lin_diag_pkg::SES_CONNECTED;
            clr_en = 1'b1;
          end
        end
        lin_diag_pkg::OP_SEND: begin
          accept = ch_ok && !pend_r && tx_st_r == lin_diag_pkg::TX_IDLE
            && state_r[chi] == lin_diag_pkg::SES_CONNECTED
            && len_send != 16'h0000 && len_send <= SEND_MAX
            && base + {1'b0, len_send} <= DEPTH_C;
          if (accept) begin
            pend_nxt = 1'b1;
            pend_chan_nxt = chi;
            pend_left_nxt = len_send;
            pend_send_nxt = param0_r[16];
            pend_func_nxt = mode[0];
            pend_nr_nxt = mode[lin_diag_pkg::MODE_NO_RESP_BIT];
            pend_seg_nxt = param1_r[0];
            req_cnt_nxt[chi] = base[AW:0];
          end
        end
        lin_diag_pkg::OP_FETCH: begin
          accept = ch_ok;
          if (accept) begin
            reply0_nxt = {5'h00, state_r[chi],
              4'h0, avail != 16'h0000, rsp_done_r[chi], busy_r[chi], rsp_seg_r[chi],
              err_q[chi], ch8};
            reply1_nxt = {avail - chunk, chunk};
            rx_chan_nxt = chi;
            rx_left_nxt = chunk;
          end
        end
        lin_diag_pkg::OP_STOP: begin
          accept = ch_ok && !pend_r && len_stop <= STOP_MAX
            && (len_stop == 16'h0000 || tx_st_r == lin_diag_pkg::TX_IDLE);
          if (accept) begin
            state_nxt[chi] = lin_diag_pkg::SES_RELEASED;
            if (len_stop != 16'h0000) begin
              clr_en = 1'b1;
              pend_nxt = 1'b1;
              pend_chan_nxt = chi;
              pend_left_nxt = len_stop;
              pend_send_nxt = 1'b1;
              pend_func_nxt = mode[0];
              pend_nr_nxt = mode[lin_diag_pkg::MODE_NO_RESP_BIT];
              pend_seg_nxt = 1'b0;
              req_cnt_nxt[chi] = '0;
            end
          end
        end
        lin_diag_pkg::OP_STATE: begin
          accept = ch_ok;
          if (accept) begin
            // Reported value is the one held before this command's clear
            reply0_nxt = {5'h00, state_r[chi], diag_type, err_q[chi], ch8};
            reply1_nxt = {30'h0000_0000, avail != 16'h0000, busy_r[chi]};
            clr_en = param0_r[8];
          end
        end
        default: accept = 1'b0;
      endcase
      reject_nxt = !accept;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {pready_r, pslverr_r, reject_r} <= 3'h0;
      {prdata_r, param0_r, param1_r} <= {3{lin_diag_pkg::WORD_RESET}};
      {reply0_r, reply1_r} <= {2{lin_diag_pkg::WORD_RESET}};
      state_r <= {NCH{lin_diag_pkg::SES_UNINIT}};
      {req_cnt_r, rsp_wr_r, rsp_rd_r} <= '0;
      {rsp_seg_r, rsp_done_r, busy_r} <= '0;
      {pend_r, pend_send_r, pend_func_r, pend_nr_r, pend_seg_r} <= 5'h00;
      {pend_chan_r, rx_chan_r} <= '0;
      {pend_left_r, rx_left_r} <= 32'h0000_0000;
    end else begin
      {pready_r, pslverr_r, reject_r} <= {pready_nxt, pslverr_nxt, reject_nxt};
      {prdata_r, param0_r, param1_r} <= {prdata_nxt, param0_nxt, param1_nxt};
      {reply0_r, reply1_r} <= {reply0_nxt, reply1_nxt};
      state_r <= state_nxt;
      {req_cnt_r, rsp_wr_r, rsp_rd_r} <= {req_cnt_nxt, rsp_wr_nxt, rsp_rd_nxt};
      {rsp_seg_r, rsp_done_r, busy_r} <= {rsp_seg_nxt, rsp_done_nxt, busy_nxt};
      {pend_r, pend_send_r, pend_func_r, pend_nr_r} <= {pend_nxt, pend_send_nxt, pend_func_nxt, pend_nr_nxt};
      {pend_seg_r, pend_chan_r, rx_chan_r} <= {pend_seg_nxt, pend_chan_nxt, rx_chan_nxt};
      {pend_left_r, rx_left_r} <= {pend_left_nxt, rx_left_nxt};
    end
  end

  // ****************************************
  // Request transmitter
  // ****************************************
  // A byte is fetched in LOAD and held in SHOW until the link takes it
  always_comb begin
    {tx_st_nxt, tx_chan_nxt, tx_ptr_nxt, tx_total_nxt} = {tx_st_r, tx_chan_r, tx_ptr_r, tx_total_r};
    {tx_data_nxt, tx_valid_nxt, tx_last_nxt} = {tx_data_r, tx_valid_r, tx_last_r};
    {tx_func_nxt, tx_nr_nxt, tx_seg_nxt} = {tx_func_r, tx_nr_r, tx_seg_r};
    unique case (tx_st_r)
      lin_diag_pkg::TX_IDLE: begin
        if (tx_start) begin
          tx_st_nxt = lin_diag_pkg::TX_LOAD;
          tx_chan_nxt = pend_chan_r;
          tx_ptr_nxt = '0;
          tx_total_nxt = req_cnt_r[pend_chan_r] + 1'b1;
          {tx_func_nxt, tx_nr_nxt, tx_seg_nxt} = {pend_func_r, pend_nr_r, pend_seg_r};
        end
      end
      lin_diag_pkg::TX_LOAD: begin
        tx_data_nxt = req_rd_data;
        tx_valid_nxt = 1'b1;
        tx_last_nxt = tx_ptr_r + 1'b1 == tx_total_r;
        tx_st_nxt = lin_diag_pkg::TX_SHOW;
      end
      lin_diag_pkg::TX_SHOW: begin
        if (tx_ready) begin
          tx_valid_nxt = 1'b0;
          tx_last_nxt = 1'b0;
          tx_ptr_nxt = tx_ptr_r + 1'b1;
          tx_st_nxt = tx_last_r ? lin_diag_pkg::TX_IDLE : lin_diag_pkg::TX_LOAD;
        end
      end
      default: tx_st_nxt = lin_diag_pkg::TX_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_r <= lin_diag_pkg::TX_IDLE;
      {tx_chan_r, tx_ptr_r, tx_total_r} <= '0;
      {tx_data_r, tx_valid_r, tx_last_r} <= 10'h000;
      {tx_func_r, tx_nr_r, tx_seg_r} <= 3'h0;
    end else begin
      tx_st_r <= tx_st_nxt;
      {tx_chan_r, tx_ptr_r, tx_total_r} <= {tx_chan_nxt, tx_ptr_nxt, tx_total_nxt};
      {tx_data_r, tx_valid_r, tx_last_r} <= {tx_data_nxt, tx_valid_nxt, tx_last_nxt};
      {tx_func_r, tx_nr_r, tx_seg_r} <= {tx_func_nxt, tx_nr_nxt, tx_seg_nxt};
    end
  end

  // ****************************************
  // Storage and outputs
  // ****************************************
  diag_buffer #(.NCH(NCH), .DEPTH(BUF_DEPTH), .CW(CW), .AW(AW)) u_req_buf (
    .pclk(pclk), .presetn(presetn), .wr_en(txd_go), .wr_chan(pend_chan_r),
    .wr_idx(req_cnt_r[pend_chan_r][AW-1:0]), .wr_data(pwdata[7:0]),
    .rd_chan(tx_chan_r), .rd_idx(tx_ptr_r[AW-1:0]), .rd_data(req_rd_data));

  diag_buffer #(.NCH(NCH), .DEPTH(BUF_DEPTH), .CW(CW), .AW(AW)) u_rsp_buf (
    .pclk(pclk), .presetn(presetn), .wr_en(rsp_ok), .wr_chan(rsp_chan),
    .wr_idx(rsp_wr_r[rsp_chan][AW-1:0]), .wr_data(rsp_data),
    .rd_chan(rx_chan_r), .rd_idx(rsp_rd_r[rx_chan_r][AW-1:0]), .rd_data(rsp_rd_data));

  chan_error #(.NCH(NCH), .CW(CW)) u_err (
    .pclk(pclk), .presetn(presetn), .set_en(err_valid && err_chan <= CW'(NCH - 1)),
    .set_chan(err_chan), .set_code(err_code), .clr_en(clr_en), .clr_chan(chi), .err_q(err_q));

  assign {pready, prdata, pslverr} = {pready_r, prdata_r, pslverr_r};
  assign {tx_valid, tx_data, tx_last, tx_chan} = {tx_valid_r, tx_data_r, tx_last_r, tx_chan_r};
  assign {tx_functional, tx_no_resp, tx_seg} = {tx_func_r, tx_nr_r, tx_seg_r};

  // ****************************************
  // Checks
  // ****************************************
  a_send_needs_conn: assert property (cmd_go && pwdata[7:0] == lin_diag_pkg::OP_SEND
    && state_r[chi] != lin_diag_pkg::SES_CONNECTED |=> reject_r && $stable(pend_r))
    else $error("send accepted without connection");
  a_send_starts_tx: assert property (txd_go && pend_left_r == 16'h0001 && pend_send_r
    |=> tx_st_r == lin_diag_pkg::TX_LOAD ##1 tx_valid)
    else $error("buffered request not sent");
  a_store_only: assert property (txd_go && pend_left_r == 16'h0001 && !pend_send_r
    |=> tx_st_r == lin_diag_pkg::TX_IDLE && !pend_r)
    else $error("store-only request was sent");
  a_overwrite_base: assert property (cmd_go && pwdata[7:0] == lin_diag_pkg::OP_SEND
    && accept && !param0_r[24] |=> req_cnt_r[$past(chi)] == '0)
    else $error("buffer not restarted");
  a_final_zero: assert property (cmd_go && pwdata[7:0] == lin_diag_pkg::OP_FETCH && ch_ok
    && avail <= SEND_MAX |=> reply1_r[31:16] == 16'h0000 && rx_left_r == reply1_r[15:0])
    else $error("final fetch remaining not zero");
  a_stop_release: assert property (cmd_go && pwdata[7:0] == lin_diag_pkg::OP_STOP && accept
    |=> state_r[$past(chi)] == lin_diag_pkg::SES_RELEASED)
    else $error("stop did not release");
  a_state_report: assert property (cmd_go && pwdata[7:0] == lin_diag_pkg::OP_STATE && ch_ok
    |=> reply0_r[15:8] == $past(err_q[chi]))
    else $error("reported error not pre-clear value");
  a_no_resp_idle: assert property (tx_done && tx_nr_r && !(rsp_ok && rsp_chan == tx_chan_r)
    |=> !busy_r[$past(tx_chan_r)])
    else $error("busy kept for no-response request");
  a_pready_wait: assert property (psel && penable && !pready_r |=> pready ##1 !pready)
    else $error("apb answer timing");

endmodule : lin_diag_session_cmds

/* lin_diag_session_cmds_tb_top.sv */
// Self-checking bench for the diagnostic command block over APB.
// Assumes default parameters (two channels) and the link model beside it.
module lin_diag_session_cmds_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slverr;
  logic [7:0] paddr = 8'h00, diag_type = 8'h02, tx_data, rsp_data, err_code;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, tx_valid, tx_ready, tx_last, tx_chan, tx_functional;
  logic tx_no_resp, tx_seg, rsp_valid, rsp_chan, rsp_last, rsp_seg, err_valid, err_chan;
  int n_fail = 0, samples_checked = 0, cycles = 0;
  always #4 pclk = ~pclk;
  lin_diag_session_cmds DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .tx_last(tx_last), .tx_chan(tx_chan), .tx_functional(tx_functional),
    .tx_no_resp(tx_no_resp), .tx_seg(tx_seg), .rsp_valid(rsp_valid), .rsp_chan(rsp_chan),
    .rsp_data(rsp_data), .rsp_last(rsp_last), .rsp_seg(rsp_seg), .err_valid(err_valid),
    .err_chan(err_chan), .err_code(err_code), .diag_type(diag_type));
  lin_link_model LINK (.pclk(pclk), .presetn(presetn), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_functional(tx_functional),
    .tx_ready(tx_ready), .rsp_valid(rsp_valid), .rsp_chan(rsp_chan), .rsp_data(rsp_data),
    .rsp_last(rsp_last), .rsp_seg(rsp_seg), .err_valid(err_valid), .err_chan(err_chan),
    .err_code(err_code));
  // APB transfer; request held until pready is seen at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk) penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    {rd, slverr} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask : apb
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task cmd(input logic [31:0] p0, input logic [31:0] p1, input logic [7:0] op);
    apb(1, lin_diag_pkg::ADDR_PARAM0, p0);
    apb(1, lin_diag_pkg::ADDR_PARAM1, p1);
    apb(1, lin_diag_pkg::ADDR_OPCODE, {24'h00_0000, op});
  endtask : cmd
  task state_is(input logic [31:0] p0, input logic [31:0] exp);
    cmd(p0, 32'h0000_0000, lin_diag_pkg::OP_STATE);
    apb(0, lin_diag_pkg::ADDR_REPLY0, 32'h0000_0000);
    chk(rd, exp);
  endtask : state_is
  // Two bytes stored, one appended and sent without response; segmentation clear
  task t_send;
    cmd(32'h0000_0000, 32'h0000_0000, lin_diag_pkg::OP_START);
    cmd(32'h0000_0100, 32'h0002_0000, lin_diag_pkg::OP_SEND);
    for (int i = 0; i < 2; i++) apb(1, lin_diag_pkg::ADDR_TXDATA, 32'h0000_0022 + i);
    cmd(32'h0101_8100, 32'h0001_0000, lin_diag_pkg::OP_SEND);
    apb(1, lin_diag_pkg::ADDR_TXDATA, 32'h0000_0024);
    for (int k = 0; k < 200 && LINK.n_got < 3; k++) @(posedge pclk);
    chk({LINK.got[0], LINK.got[1], LINK.got[2], 6'h00, LINK.got_fn, LINK.got_last},
      32'h2223_2403);
    chk({29'h0000_0000, tx_chan, tx_no_resp, tx_seg}, 32'h0000_0002);
  endtask : t_send
  // Two-byte response read back through the fetch command
  task t_fetch;
    LINK.rsp(8'h62, 1'b0);
    LINK.rsp(8'h7F, 1'b1);
    cmd(32'h0000_0000, 32'h0000_0000, lin_diag_pkg::OP_FETCH);
    apb(0, lin_diag_pkg::ADDR_REPLY0, 32'h0000_0000);
    chk(rd, 32'h030C_0000);
    apb(0, lin_diag_pkg::ADDR_REPLY1, 32'h0000_0000);
    chk(rd, 32'h0000_0002);
    apb(0, lin_diag_pkg::ADDR_RXDATA, 32'h0000_0000);
    chk(rd, 32'h0000_0062);
    apb(0, lin_diag_pkg::ADDR_RXDATA, 32'h0000_0000);
    chk(rd, 32'h0000_007F);
    cmd(32'h0000_0000, 32'h0000_0000, lin_diag_pkg::OP_FETCH);
    apb(0, lin_diag_pkg::ADDR_REPLY0, 32'h0000_0000);
    chk(rd, 32'h0300_0000);
  endtask : t_fetch
  // Error is reported before clearing, then gone; restart clears too
  task t_state;
    LINK.err(8'h55);
    state_is(32'h0000_0100, 32'h0302_5500);
    state_is(32'h0000_0000, 32'h0302_0000);
    LINK.err(8'h31);
    cmd(32'h0000_0000, 32'h0000_0000, lin_diag_pkg::OP_START);
    state_is(32'h0000_0000, 32'h0302_0000);
  endtask : t_state
  // Unmapped address, send on an idle channel, stop, then send after release
  task t_refuse;
    apb(0, 8'h40, 32'h0000_0000);
    chk({31'h0, slverr}, 32'h0000_0001);
    cmd(32'h0001_0001, 32'h0001_0000, lin_diag_pkg::OP_SEND);
    apb(0, lin_diag_pkg::ADDR_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0004);
    cmd(32'h0000_0000, 32'h0000_0000, lin_diag_pkg::OP_STOP);
    state_is(32'h0000_0000, 32'h0402_0000);
    cmd(32'h0001_0000, 32'h0001_0000, lin_diag_pkg::OP_SEND);
    apb(0, lin_diag_pkg::ADDR_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0004);
  endtask : t_refuse
  task summarize;
    $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  // Hang guard: the whole run needs well under this many cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_send();
    t_fetch();
    t_state();
    t_refuse();
    summarize();
  end
endmodule : lin_diag_session_cmds_tb_top

/* lin_link_model.sv */
// Link engine stand-in: takes request bytes and injects responses and errors.
// Assumes one pclk domain and a single-bit channel field (two channels).
module lin_link_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_functional,
  output logic tx_ready,
  output logic rsp_valid,
  output logic rsp_chan,
  output logic [7:0] rsp_data,
  output logic rsp_last,
  output logic rsp_seg,
  output logic err_valid,
  output logic err_chan,
  output logic [7:0] err_code
);
  logic [7:0] got [0:15];
  logic got_last = 1'b0;
  logic got_fn = 1'b0;
  int n_got = 0;
  initial {rsp_valid, rsp_chan, rsp_data, rsp_last, rsp_seg} = 12'h000;
  initial {err_valid, err_chan, err_code} = 10'h000;
  // Ready alternates so takes see both a prompt and a stalled link
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tx_ready <= 1'b0;
    else tx_ready <= ~tx_ready;
  end
  // Capture each byte at its take, with the frame flags it carries
  always @(posedge pclk) begin
    if (tx_valid && tx_ready) begin
      got[n_got[3:0]] <= tx_data;
      got_last <= tx_last;
      got_fn <= tx_functional;
      n_got <= n_got + 1;
    end
  end
  // One response byte on channel 0; data is scrambled once released
  task rsp(input logic [7:0] d, input logic last);
    @(posedge pclk) {rsp_valid, rsp_data, rsp_last} <= {1'b1, d, last};
    @(posedge pclk) {rsp_valid, rsp_data, rsp_last} <= {1'b0, ~d, 1'b0};
  endtask : rsp
  task err(input logic [7:0] c);
    @(posedge pclk) {err_valid, err_code} <= {1'b1, c};
    @(posedge pclk) {err_valid, err_code} <= {1'b0, ~c};
  endtask : err
endmodule : lin_link_model
